/* File: dv/eprom_device_model.sv */
// Behavioural word-wide EPROM that answers the host's pins.
// Assumes the bench resolves the shared data wire from devOe.
`timescale 1ns/100ps
module eprom_device_model
	import eprom_host_pkg::*;
#(
	parameter logic [15:0] MFG_CODE = 16'h5A3C, // Arbitrary value
	parameter logic [15:0] DEV_CODE = 16'hC3A5 // Arbitrary value
) (
	// Pins driven by the host
	input wire logic [ADDR_W-1:0] addr,
	input wire logic ceN,
	input wire logic oeN,
	input wire logic pgmN,
	input wire logic vppOn,
	input wire logic sigOn,
	input wire logic [DATA_W-1:0] dataBus,
	// Strobes ignored per word before cells take charge
	input wire integer lazy,
	// Data driven back
	output logic devOe,
	output logic [DATA_W-1:0] devData
);
	logic [DATA_W-1:0] mem [2**ADDR_W];
	int skipped;
	// ********************************************************************
	// Cell array
	// ********************************************************************
	// Blank part reads all ones
	initial begin
		foreach (mem[i]) mem[i] = 16'hFFFF;
		skipped = 0;
	end
	// Burn at strobe end; select high inhibits, and a slow cell ignores its first lazy strobes
	always @(posedge pgmN) begin
		if (vppOn && !ceN && oeN) begin
			if (skipped < lazy)
				skipped++;
			else begin
				mem[addr] &= dataBus;
				skipped = 0;
			end
		end
	end
	// Drivers on only when selected with output drive low
	assign devOe = !ceN && !oeN;
	assign devData = sigOn ? (addr[CODE_LINE_BIT] ? DEV_CODE : MFG_CODE)
		: mem[addr];
endmodule

/* File: dv/tb_eprom_host.sv */
// Self-checking bench for the EPROM host controller.
// Assumes the device model of this folder on the far side.
`timescale 1ns/100ps
module tb_eprom_host;
	import eprom_host_pkg::*;
	localparam int TRIES = 3;
	localparam logic [15:0] MFG = 16'h5A3C; // Arbitrary value
	localparam logic [15:0] DEV = 16'hC3A5; // Arbitrary value
	logic clk = 0, rst = 1, cmdValid = 0, cmdCodeSel = 0, cmdSlow = 0;
	logic [1:0] cmdOp = 0;
	logic [15:0] cmdAddr = 0, cmdData = 0, lastBus = 0, a, d;
	logic cmdReady, rspValid, rspOk, ceN, oeN, pgmN, vppOn, sigOn, dataOeN;
	logic devOe;
	logic [15:0] rspData, addr, dataOut, devData, dataIn;
	logic [7:0] rspTries;
	logic [24:0] expQ [$];
	logic [24:0] e;
	logic [31:0] seed = 32'h0341;
	int lazy = 0, failures = 0, cmp_count = 0, cycles = 0;
	always #12.5 clk = ~clk;
	// Floating wire shows a changing pattern, never a stale word
	assign dataIn = !dataOeN ? dataOut : devOe ? devData : ~lastBus;
	always @(posedge clk) lastBus <= dataIn;
	eprom_host #(.PULSE_SLOW_CYC(50), .MAX_TRIES(TRIES)) dut (.clk(clk),
		.rst(rst), .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdAddr(cmdAddr),
		.cmdData(cmdData), .cmdCodeSel(cmdCodeSel), .cmdSlow(cmdSlow),
		.cmdReady(cmdReady), .rspValid(rspValid), .rspOk(rspOk),
		.rspData(rspData), .rspTries(rspTries), .addr(addr), .ceN(ceN),
		.oeN(oeN), .pgmN(pgmN), .vppOn(vppOn), .sigOn(sigOn),
		.dataIn(dataIn), .dataOut(dataOut), .dataOeN(dataOeN));
	eprom_device_model #(.MFG_CODE(MFG), .DEV_CODE(DEV)) part (.addr(addr),
		.ceN(ceN), .oeN(oeN), .pgmN(pgmN), .vppOn(vppOn), .sigOn(sigOn),
		.dataBus(dataIn), .lazy(lazy), .devOe(devOe), .devData(devData));
	// ********************************************************************
	// Helpers
	// ********************************************************************
	function automatic logic [15:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction
	task automatic cmpWord(input logic [15:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t word %h want %h", $time, got, exp);
		end
	endtask
	task automatic cmpFlag(input logic got, exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t flag %b want %b", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		if (failures == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Request held until the edge that takes it, then the answer noted
	task automatic send(input logic [1:0] op, input logic [15:0] ad, dt,
		input logic sel, slow, ok, input logic [15:0] xd, input int xt);
		// One edge between calls, so valid never rises as it falls
		@(posedge clk);
		#1 cmdValid = 1;
		cmdOp = op;
		cmdAddr = ad;
		cmdData = dt;
		cmdCodeSel = sel;
		cmdSlow = slow;
		do @(posedge clk); while (cmdReady !== 1'b1);
		expQ.push_back({ok, xd, xt[7:0]});
		#1 cmdValid = 0;
	endtask
	// ********************************************************************
	// Answer watcher and hang guard
	// ********************************************************************
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			failures++;
			$display("ERROR %0t run timed out", $time);
			report_and_stop();
		end
		if (rspValid === 1'b1) begin
			if (expQ.size() == 0) begin
				failures++;
				$display("ERROR %0t answer without command", $time);
			end else begin
				e = expQ.pop_front();
				cmpFlag(rspOk, e[24]);
				cmpWord(rspData, e[23:8]);
				cmpWord({8'h00, rspTries}, {8'h00, e[7:0]});
			end
		end
	end
	// Main sequence
	initial begin
		repeat (20) @(posedge clk);
		#1 rst = 0;
		send(OP_SIGNATURE, rnd(), rnd(), 0, 0, 1, MFG, 0);
		send(OP_SIGNATURE, rnd(), rnd(), 1, 0, 1, DEV, 0);
		for (int i = 0; i < 3; i++) begin
			a = rnd();
			d = rnd() & 16'hFFFE;
			send(OP_READ, a, rnd(), 0, 0, 1, 16'hFFFF, 0);
			send(OP_PROGRAM, a, d, 0, i[0], 1, d, 1);
			send(OP_READ, a, rnd(), 0, 0, 1, d, 0);
		end
		send(2'h3, a, rnd(), 0, 0, 1, d, 0);
		send(OP_PROGRAM, a, ~d, 0, 1, 0, 16'h0000, TRIES);
		// Slow cells only once the last word is done, else skips leak over
		wait (expQ.size() == 0);
		lazy = 1;
		send(OP_PROGRAM, a ^ 16'h0100, d, 0, 0, 1, d, 2);
		wait (expQ.size() == 0);
		repeat (4) @(posedge clk);
		report_and_stop();
	end
endmodule

/* File: logic/eprom_host.sv */
// Host controller that reads, programs and identifies a 64K x 16 EPROM.
// Assumes the programmer supply switches follow vppOn and sigOn, and that
// the testbench resolves the shared data wire from dataOeN.
`timescale 1ns/100ps
module eprom_host
	import eprom_host_pkg::*;
#(
	parameter int PULSE_SLOW_CYC = SLOW_PULSE_CYC,
	parameter int MAX_TRIES = MAX_TRIES_DEF
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Command side
	input wire logic cmdValid,
	input wire logic [1:0] cmdOp,
	input wire logic [ADDR_W-1:0] cmdAddr,
	input wire logic [DATA_W-1:0] cmdData,
	input wire logic cmdCodeSel,
	input wire logic cmdSlow,
	output logic cmdReady,
	// Answer side
	output logic rspValid,
	output logic rspOk,
	output logic [DATA_W-1:0] rspData,
	output logic [TRIES_W-1:0] rspTries,
	// Memory pins
	output logic [ADDR_W-1:0] addr,
	output logic ceN,
	output logic oeN,
	output logic pgmN,
	output logic vppOn,
	output logic sigOn,
	input wire logic [DATA_W-1:0] dataIn,
	output logic [DATA_W-1:0] dataOut,
	output logic dataOeN
);
	// ****************************************************************
	// State and timing
	// ****************************************************************
	typedef enum {ST_IDLE, ST_SETUP, ST_PULSE, ST_HOLD, ST_GAP, ST_VERIFY,
		ST_FLOAT, ST_READ, ST_DONE} state_e;

	state_e state;
	logic [TIMER_W-1:0] timer;
	logic [TRIES_W-1:0] tries;
	logic [DATA_W-1:0] wantData;
	logic isSlow;

	function automatic logic [TIMER_W-1:0] load(input int cyc);
		load = TIMER_W'(cyc - 1);
	endfunction

	// Decoding of the present step
	wire timerDone = (timer == '0);
	wire accepted = cmdValid && cmdReady;
	wire verifyMatch = (dataIn == wantData);
	wire triesLeft = (tries < TRIES_W'(MAX_TRIES));
	wire [TIMER_W-1:0] pulseLoad = isSlow ? load(PULSE_SLOW_CYC) :
		load(FAST_PULSE_CYC);
	wire [ADDR_W-1:0] sigAddr = (cmdAddr | (ADDR_W'(1) << SIG_LINE_BIT)) &
		~(ADDR_W'(1) << CODE_LINE_BIT) |
		(ADDR_W'(cmdCodeSel) << CODE_LINE_BIT);

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	// One sequencer owns every pin so mode changes stay glitch-ordered
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= ST_IDLE;
			timer <= '0;
			tries <= '0;
			wantData <= '0;
			isSlow <= 1'b0;
			cmdReady <= 1'b0;
			rspValid <= 1'b0;
			rspOk <= 1'b0;
			rspData <= '0;
			rspTries <= '0;
			addr <= '0;
			ceN <= 1'b1;
			oeN <= 1'b1;
			pgmN <= 1'b1;
			vppOn <= 1'b0;
			sigOn <= 1'b0;
			dataOut <= '0;
			dataOeN <= 1'b1;
		end else begin
			rspValid <= 1'b0;
			if (!timerDone) timer <= timer - 1'b1;
			unique case (state)
			ST_IDLE: begin
				cmdReady <= 1'b1;
				if (accepted) begin
					cmdReady <= 1'b0;
					ceN <= 1'b0;
					addr <= cmdAddr;
					tries <= '0;
					isSlow <= cmdSlow;
					if (cmdOp == OP_PROGRAM) begin
						vppOn <= 1'b1;
						dataOut <= cmdData;
						dataOeN <= 1'b0;
						wantData <= cmdData;
						timer <= load(SETUP_CYC);
						state <= ST_SETUP;
					end else if (cmdOp == OP_SIGNATURE) begin
						sigOn <= 1'b1;
						addr <= sigAddr;
						timer <= load(SETUP_CYC);
						state <= ST_SETUP;
					end else begin
						oeN <= 1'b0;
						timer <= load(ACCESS_CYC);
						state <= ST_READ;
					end
				end
			end
			// Address, data and supplies settle before strobe or read
			ST_SETUP: if (timerDone) begin
				if (sigOn) begin
					oeN <= 1'b0;
					timer <= load(ACCESS_CYC);
					state <= ST_READ;
				end else begin
					pgmN <= 1'b0;
					timer <= pulseLoad;
					tries <= tries + 1'b1;
					state <= ST_PULSE;
				end
			end
			ST_PULSE: if (timerDone) begin
				pgmN <= 1'b1;
				timer <= load(SETUP_CYC);
				state <= ST_HOLD;
			end
			// Data hold, then release the bus before output drive falls
			ST_HOLD: if (timerDone) begin
				dataOeN <= 1'b1;
				state <= ST_GAP;
			end
			ST_GAP: begin
				oeN <= 1'b0;
				timer <= load(ACCESS_CYC);
				state <= ST_VERIFY;
			end
			// Only reached from a pulse, so verify never doubles as a read
			ST_VERIFY: if (timerDone) begin
				oeN <= 1'b1;
				rspData <= dataIn;
				// Every bit must read back as in the wanted word
				if (verifyMatch || !triesLeft) begin
					rspOk <= verifyMatch;
					state <= ST_DONE;
				end else begin
					timer <= load(FLOAT_CYC);
					state <= ST_FLOAT;
				end
			end
			// Wait for the part to float before driving data again
			ST_FLOAT: if (timerDone) begin
				dataOeN <= 1'b0;
				timer <= load(SETUP_CYC);
				state <= ST_SETUP;
			end
			ST_READ: if (timerDone) begin
				rspData <= dataIn;
				rspOk <= 1'b1;
				oeN <= 1'b1;
				state <= ST_DONE;
			end
			// Deselect first; supplies drop with it into standby
			ST_DONE: begin
				ceN <= 1'b1;
				vppOn <= 1'b0;
				sigOn <= 1'b0;
				rspValid <= 1'b1;
				rspTries <= tries;
				state <= ST_IDLE;
			end
			endcase
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Helper: length of the present or last strobe pulse
	logic [TIMER_W:0] pulseLen;
	always_ff @(posedge clk) begin
		if (rst) pulseLen <= '0;
		else if (!pgmN) pulseLen <= pulseLen + 1'b1;
		// Cleared once high; the rising check still sees the old count
		else pulseLen <= '0;
	end

	chk_no_bus_fight: assert property (!(!oeN && !dataOeN))
		else $error("host drives data while part outputs");
	chk_program_setup: assert property (!pgmN |->
		vppOn && !ceN && oeN && !dataOeN && !sigOn)
		else $error("strobe low outside program conditions");
	chk_verify_setup: assert property ((vppOn && !oeN) |->
		pgmN && !ceN && dataOeN)
		else $error("verify conditions broken");
	chk_read_mode: assert property ((state == ST_READ) |->
		!ceN && !oeN && !vppOn && pgmN)
		else $error("read without normal read conditions");
	chk_standby_float: assert property (ceN |->
		dataOeN && pgmN && !vppOn)
		else $error("deselected part not left idle");
	chk_sig_normal: assert property (sigOn |->
		!vppOn && !ceN && addr[SIG_LINE_BIT])
		else $error("signature voltage with programming supply");
	chk_sig_code_held: assert property ((sigOn && $past(sigOn)) |->
		$stable(addr[CODE_LINE_BIT]))
		else $error("code line moved during signature");
	chk_pulse_width: assert property ($rose(pgmN) |->
		(pulseLen == (TIMER_W+1)'(FAST_PULSE_CYC)) ||
		(pulseLen == (TIMER_W+1)'(PULSE_SLOW_CYC)))
		else $error("strobe pulse width wrong");
	chk_retry_loop: assert property ((state == ST_VERIFY && timerDone &&
		!verifyMatch && triesLeft) |=> (state == ST_FLOAT) ##[1:8]
		(state == ST_SETUP && !dataOeN))
		else $error("failed verify did not retry");
	chk_verify_after_pulse: assert property ($fell(oeN) && vppOn |->
		$past(state, 1) == ST_GAP)
		else $error("verify not preceded by a pulse");
	chk_done_answer: assert property ((state == ST_DONE) |=>
		rspValid && ceN ##1 !rspValid)
		else $error("answer not one pulse");

	cov_read: cover property (state == ST_READ && timerDone && !sigOn);
	cov_sig: cover property (state == ST_READ && timerDone && sigOn);
	cov_prog_pass: cover property (rspValid && rspOk && rspTries != '0);
	cov_prog_retry: cover property (state == ST_FLOAT);
endmodule

/* File: logic/eprom_host_pkg.sv */
// Constants, timing counts and command codes for the word-wide EPROM host.
// Assumes a 40 MHz clock and a part that needs no clock of its own.
// ********************************************************************
// Behaviour
// - Program: high supply, select low, output drive high, strobe low, data.
// - Verify: high supply kept, select and output drive low, strobe high.
// - Verify is used only to check a word just programmed, never for reads.
// - Signature voltage on its line, code line low, reads the maker code.
// - Strobe pulses last 100 us (fast) or 1.0 ms (slow algorithm).
// ********************************************************************
package eprom_host_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int TIMER_W = 16;
	localparam int TRIES_W = 8;
	localparam int CLK_PERIOD_NS = 25;
	// Least times, rounded up to whole cycles
	localparam int T_SETUP_NS = 2000;
	localparam int T_ACCESS_NS = 150;
	localparam int T_FLOAT_NS = 130;
	// Nominal pulse widths, rounded down
	localparam int T_FAST_PULSE_NS = 100000;
	localparam int T_SLOW_PULSE_NS = 1000000;
	localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACCESS_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FLOAT_CYC = (T_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FAST_PULSE_CYC = T_FAST_PULSE_NS / CLK_PERIOD_NS;
	localparam int SLOW_PULSE_CYC = T_SLOW_PULSE_NS / CLK_PERIOD_NS;
	localparam int SIG_LINE_BIT = 9;
	localparam int CODE_LINE_BIT = 0;
	localparam int MAX_TRIES_DEF = 25;
	localparam logic [1:0] OP_READ = 2'h0;
	localparam logic [1:0] OP_PROGRAM = 2'h1;
	localparam logic [1:0] OP_SIGNATURE = 2'h2;
endpackage
